// file: hw/charge_enable_and_gate_sequencer.sv
// Purpose: qualifies charging and sequences the buck gate commands
// Assumes: sense inputs are synchronous to clk; duty is in 1/256 steps
// Notes:   duty 8'hff means full duty, with a bootstrap refresh only when the bootstrap sense stays low
`timescale 1ns/100ps
`include "charge_seq_regs.svh"

module charge_enable_and_gate_sequencer #(
	parameter int QUAL_CYCLES = `QUAL_CYC
) (
	input  wire logic                      clk,
	input  wire logic                      rst_b,
	input  wire charge_seq_pkg::regReq_t   regReq,
	output      logic [31:0]               rdata,
	input  wire logic                      chargeAllowPin_b,
	input  wire charge_seq_pkg::senseIn_t  sense,
	input  wire logic [7:0]                duty,
	output      charge_seq_pkg::gateCmd_t  gates,
	output      logic                      irq
);
	import charge_seq_pkg::*;

	// ----------------------------------------------------------------
	// elaboration checks
	// ----------------------------------------------------------------
	generate
		if (QUAL_CYCLES < 1 || QUAL_CYCLES > 16777215) begin : badQual
			$error("QUAL_CYCLES outside the 24-bit counter range");
		end
	endgenerate

	localparam logic [6:0] PER_LO = 7'(`PER_LO_CYC);
	localparam logic [6:0] PER_HI = 7'(`PER_HI_CYC);
	localparam logic [1:0] PULSE  = 2'(`PULSE_CYC);
	localparam logic [1:0] DEAD   = 2'(`DEAD_CYC);
	localparam logic [23:0] QUAL  = 24'(QUAL_CYCLES);

	// ----------------------------------------------------------------
	// reset release
	// ----------------------------------------------------------------
	logic rstMeta_q;
	logic rstSync_q;

	// release is synchronised so all flops leave reset on one edge
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rstMeta_q <= 1'b0;
			rstSync_q <= 1'b0;
		end else begin
			rstMeta_q <= 1'b1;
			rstSync_q <= rstMeta_q;
		end
	end

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	logic        ctrlStop_q;
	logic        ctrlFsel_q;
	logic [3:0]  intSts_q;
	logic [3:0]  intMask_q;
	logic [23:0] qualCnt_q;
	logic        qualDone_q;
	logic        stsUnready_q;
	logic        stsOff_q;
	logic        unready;
	logic        run;
	logic [6:0]  period;
	logic [6:0]  cnt_q;
	logic [6:0]  cntNext;
	logic        wrap;
	logic [14:0] prod;
	logic [6:0]  onCycles;
	logic        fullDuty;
	logic        zeroDuty;
	logic [1:0]  bootCnt_q;
	logic        refreshReq_q;
	logic        refreshing_q;
	logic        pulseMode_q;
	logic [1:0]  tmr_q;
	gateState_t  state_q;
	gateState_t  state_d;
	logic        regHit;
	logic [3:0]  intSet;
	logic [31:0] rdMux;

	// ----------------------------------------------------------------
	// control registers
	// ----------------------------------------------------------------
	// stop bit comes up set so nothing switches before software agrees
	always_ff @(posedge clk or negedge rstSync_q) begin
		if (!rstSync_q) begin
			ctrlStop_q <= `CTRL_STOP_RST;
			ctrlFsel_q <= `CTRL_FSEL_RST;
			intMask_q  <= `INT_MASK_RST;
		end else if (regReq.wr) begin
			if (regReq.addr == `OFS_CTRL) begin
				ctrlStop_q <= regReq.wdata[`CTRL_STOP_BIT];
				ctrlFsel_q <= regReq.wdata[`CTRL_FSEL_BIT];
			end
			if (regReq.addr == `OFS_INT_MASK) begin
				intMask_q <= regReq.wdata[3:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// adapter qualification
	// ----------------------------------------------------------------
	// timer restarts on any adapter drop so a bouncing plug never counts
	always_ff @(posedge clk or negedge rstSync_q) begin
		if (!rstSync_q) begin
			qualCnt_q  <= 24'h000000;
			qualDone_q <= 1'b0;
		end else if (!sense.adapterPresent) begin
			qualCnt_q  <= 24'h000000;
			qualDone_q <= 1'b0;
		end else if (!qualDone_q) begin
			if (qualCnt_q == QUAL - 24'h000001) begin
				qualDone_q <= 1'b1;
			end else begin
				qualCnt_q <= qualCnt_q + 24'h000001;
			end
		end
	end

	// readiness and the full set of enable terms
	assign unready = !sense.adapterPresent || !qualDone_q
		|| !sense.gateRegGood || !sense.auxRegGood;
	assign run = !unready && !chargeAllowPin_b && !ctrlStop_q
		&& !sense.dieOverTemp && !sense.overCurrent
		&& sense.packTempOk;

	// status flags shown to software
	always_ff @(posedge clk or negedge rstSync_q) begin
		if (!rstSync_q) begin
			stsUnready_q <= `STS_UNREADY_RST;
			stsOff_q     <= `STS_OFF_RST;
		end else begin
			stsUnready_q <= unready;
			stsOff_q     <= !run;
		end
	end

	// ----------------------------------------------------------------
	// switching period
	// ----------------------------------------------------------------
	assign period  = ctrlFsel_q ? PER_HI : PER_LO;
	assign wrap    = (cnt_q >= period - 7'd1);
	assign cntNext = wrap ? 7'd0 : cnt_q + 7'd1;

	// free-running phase; a frequency change takes effect at once
	always_ff @(posedge clk or negedge rstSync_q) begin
		if (!rstSync_q) begin
			cnt_q <= 7'd0;
		end else begin
			cnt_q <= cntNext;
		end
	end

	// high-side on time from the requested duty
	assign prod     = 15'(duty * period);
	assign fullDuty = (duty == 8'hff);
	assign zeroDuty = (duty == 8'h00);
	assign onCycles = fullDuty ? period : prod[14:8];

	// ----------------------------------------------------------------
	// bootstrap watch
	// ----------------------------------------------------------------
	// counts whole cycles with the high side held and the bootstrap low
	always_ff @(posedge clk or negedge rstSync_q) begin
		if (!rstSync_q) begin
			bootCnt_q    <= 2'd0;
			refreshReq_q <= 1'b0;
		end else if (state_q == sDeadA || !sense.bootLow) begin
			bootCnt_q    <= 2'd0;
			refreshReq_q <= 1'b0;
		end else if (wrap && state_q == sHigh) begin
			if (bootCnt_q == 2'(`BOOT_LOW_MAX)) begin
				refreshReq_q <= 1'b1;
			end else begin
				bootCnt_q <= bootCnt_q + 2'd1;
			end
		end
	end

	// ----------------------------------------------------------------
	// gate state machine
	// ----------------------------------------------------------------
	// losing any enable term drops both gates on the next edge
	always_comb begin
		state_d = state_q;
		case (state_q)
			sIdle: begin
				if (wrap && !zeroDuty) begin
					state_d = sHigh;
				end
			end
			sHigh: begin
				if (refreshReq_q) begin
					state_d = sDeadA;
				end else if (!fullDuty && cntNext >= onCycles) begin
					state_d = sDeadA;
				end
			end
			sDeadA: begin
				if (tmr_q == 2'd0) begin
					state_d = sLow;
				end
			end
			sLow: begin
				if (pulseMode_q) begin
					if (tmr_q == 2'd0) begin
						state_d = refreshing_q ? sDeadB : sIdle;
					end
				end else if (wrap) begin
					state_d = zeroDuty ? sIdle : sDeadB;
				end
			end
			sDeadB: begin
				if (tmr_q == 2'd0) begin
					state_d = zeroDuty ? sIdle : sHigh;
				end
			end
			default: begin
				state_d = sIdle;
			end
		endcase
		if (!run) begin
			state_d = sIdle;
		end
	end

	// state, dead and pulse timer, and the mode picked at high-side off
	always_ff @(posedge clk or negedge rstSync_q) begin
		if (!rstSync_q) begin
			state_q      <= sIdle;
			tmr_q        <= 2'd0;
			pulseMode_q  <= 1'b0;
			refreshing_q <= 1'b0;
		end else begin
			state_q <= state_d;
			if (state_d != state_q) begin
				case (state_d)
					sDeadA: tmr_q  <= DEAD - 2'd1;
					sDeadB: tmr_q  <= DEAD - 2'd1;
					sLow:   tmr_q  <= PULSE - 2'd1;
					default: tmr_q <= 2'd0;
				endcase
			end else if (tmr_q != 2'd0) begin
				tmr_q <= tmr_q - 2'd1;
			end
			if (state_q == sHigh && state_d == sDeadA) begin
				refreshing_q <= refreshReq_q;
				pulseMode_q  <= refreshReq_q || !sense.aboveSync;
			end
		end
	end

	// gates straight from flops; only one state drives each side
	always_ff @(posedge clk or negedge rstSync_q) begin
		if (!rstSync_q) begin
			gates <= '0;
		end else begin
			gates.highSide <= (state_d == sHigh);
			gates.lowSide  <= (state_d == sLow);
		end
	end

	// ----------------------------------------------------------------
	// interrupts
	// ----------------------------------------------------------------
	// events: became ready, turned on, turned off, bootstrap refresh
	assign intSet[`INT_READY_BIT]   = stsUnready_q && !unready;
	assign intSet[`INT_ON_BIT]      = stsOff_q && run;
	assign intSet[`INT_OFF_BIT]     = !stsOff_q && !run;
	assign intSet[`INT_REFRESH_BIT] = state_q == sHigh && refreshReq_q
		&& run;

	// a set in the clearing cycle wins so no event is lost
	always_ff @(posedge clk or negedge rstSync_q) begin
		if (!rstSync_q) begin
			intSts_q <= 4'h0;
			irq      <= 1'b0;
		end else begin
			if (regReq.wr && regReq.addr == `OFS_INT_STS) begin
				intSts_q <= (intSts_q & ~regReq.wdata[3:0]) | intSet;
			end else begin
				intSts_q <= intSts_q | intSet;
			end
			irq <= |((intSts_q | intSet) & intMask_q);
		end
	end

	// ----------------------------------------------------------------
	// register read port
	// ----------------------------------------------------------------
	assign regHit = regReq.rd;

	// unmapped offsets read as zero
	always_comb begin
		rdMux = 32'h00000000;
		case (regReq.addr)
			`OFS_CTRL: begin
				rdMux[`CTRL_STOP_BIT] = ctrlStop_q;
				rdMux[`CTRL_FSEL_BIT] = ctrlFsel_q;
			end
			`OFS_STATUS: begin
				rdMux[`STS_UNREADY_BIT] = stsUnready_q;
				rdMux[`STS_OFF_BIT]     = stsOff_q;
			end
			`OFS_INT_STS:  rdMux[3:0] = intSts_q;
			`OFS_INT_MASK: rdMux[3:0] = intMask_q;
			default:       rdMux = 32'h00000000;
		endcase
	end

	// read data stand only in the cycle after the strobe
	always_ff @(posedge clk or negedge rstSync_q) begin
		if (!rstSync_q) begin
			rdata <= 32'h00000000;
		end else begin
			rdata <= regHit ? rdMux : 32'h00000000;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	qual_done_a: assert property (@(posedge clk) disable iff (!rstSync_q)
		$rose(qualDone_q) |-> $past(qualCnt_q) == QUAL - 24'h000001
		&& $past(sense.adapterPresent))
		else $error("qualification ended early");

	adapter_drop_a: assert property (@(posedge clk) disable iff (!rstSync_q)
		!sense.adapterPresent |=> !qualDone_q && qualCnt_q == 24'h000000)
		else $error("adapter drop did not restart timer");

	stop_bit_a: assert property (@(posedge clk) disable iff (!rstSync_q)
		ctrlStop_q |=> !gates.highSide && !gates.lowSide)
		else $error("gate active with stop bit set");

	enable_cause_a: assert property (@(posedge clk) disable iff (!rstSync_q)
		$rose(gates.highSide) |-> $past(run) && !$past(unready)
		&& !$past(sense.dieOverTemp))
		else $error("high side on without enable");

	unready_flag_a: assert property (@(posedge clk) disable iff (!rstSync_q)
		(!sense.gateRegGood || !sense.auxRegGood) |=> stsUnready_q)
		else $error("unready flag not set");

	off_flag_a: assert property (@(posedge clk) disable iff (!rstSync_q)
		gates.highSide |-> !stsOff_q)
		else $error("off flag set while switching");

	no_overlap_a: assert property (@(posedge clk) disable iff (!rstSync_q)
		!(gates.highSide && gates.lowSide) and
		($fell(gates.highSide) |-> !gates.lowSide))
		else $error("gates overlap without dead time");

	recharge_pulse_a: assert property (@(posedge clk)
		disable iff (!rstSync_q)
		($rose(gates.lowSide) && pulseMode_q && run) |->
		gates.lowSide ##1 gates.lowSide ##1 !gates.lowSide)
		else $error("recharge pulse not two cycles");

	zero_duty_a: assert property (@(posedge clk) disable iff (!rstSync_q)
		(state_q == sIdle && zeroDuty) |=> !gates.highSide)
		else $error("switch on at zero duty");

	period_a: assert property (@(posedge clk) disable iff (!rstSync_q)
		!ctrlFsel_q |=> cnt_q == (($past(cnt_q) == 7'd82) ? 7'd0
		: $past(cnt_q) + 7'd1))
		else $error("low frequency period wrong");

	refresh_a: assert property (@(posedge clk) disable iff (!rstSync_q)
		(state_q == sHigh && refreshReq_q && run) |=> state_q == sDeadA
		##1 (state_q == sLow || !$past(run)))
		else $error("bootstrap refresh not issued");

endmodule : charge_enable_and_gate_sequencer

// file: hw/charge_seq_pkg.sv
// Purpose: types of the charge enable and gate sequencer
// Assumes: constants live in charge_seq_regs.svh
// Notes:   carriers for the register port, sense inputs and gates
package charge_seq_pkg;

	// register port request from the host
	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} regReq_t;

	// analog comparator and supervisor results, all active high
	typedef struct packed {
		logic adapterPresent;
		logic gateRegGood;
		logic auxRegGood;
		logic dieOverTemp;
		logic overCurrent;
		logic packTempOk;
		logic bootLow;
		logic aboveSync;
	} senseIn_t;

	// gate commands to the external drivers
	typedef struct packed {
		logic highSide;
		logic lowSide;
	} gateCmd_t;

	typedef enum logic [2:0] {
		sIdle  = 3'b000,
		sHigh  = 3'b001,
		sDeadA = 3'b010,
		sLow   = 3'b011,
		sDeadB = 3'b100
	} gateState_t;

endpackage : charge_seq_pkg

// file: hw/charge_seq_regs.svh
// Purpose: constants of the charge enable and gate sequencer
// Assumes: 25 MHz clock, word-aligned register offsets
// Notes:   times are kept as printed; cycle counts derive from them
`ifndef CHARGE_SEQ_REGS_SVH
`define CHARGE_SEQ_REGS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define OFS_CTRL      8'h00
`define OFS_STATUS    8'h04
`define OFS_INT_STS   8'h08
`define OFS_INT_MASK  8'h0c

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define CTRL_STOP_BIT    0
`define CTRL_FSEL_BIT    5
`define STS_UNREADY_BIT  0
`define STS_OFF_BIT      1
`define INT_READY_BIT    0
`define INT_ON_BIT       1
`define INT_OFF_BIT      2
`define INT_REFRESH_BIT  3
`define CTRL_STOP_RST    1'b1
`define CTRL_FSEL_RST    1'b0
`define INT_MASK_RST     4'h0
`define STS_UNREADY_RST  1'b1
`define STS_OFF_RST      1'b1

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_HZ        25000000
`define CLK_NS        40
`define FS_LO_HZ      300000
`define FS_HI_HZ      500000
`define PER_LO_CYC    (`CLK_HZ / `FS_LO_HZ)
`define PER_HI_CYC    (`CLK_HZ / `FS_HI_HZ)
`define PULSE_NS      80
`define PULSE_CYC     ((`PULSE_NS + `CLK_NS - 1) / `CLK_NS)
`define DEAD_NS       40
`define DEAD_CYC      ((`DEAD_NS + `CLK_NS - 1) / `CLK_NS)
`define QUAL_MS       500
`define QUAL_CYC      (`QUAL_MS * (`CLK_HZ / 1000))
`define BOOT_LOW_MAX  3

`endif

// file: testbench/charge_enable_and_gate_sequencer_test.sv
// Purpose: self-checking bench of the charge sequencer
// Assumes: short qualification count, driver model on the gates
// Notes:   gate timing is measured in clk cycles from the edges seen
`timescale 1ns/100ps
`include "charge_seq_regs.svh"

module charge_enable_and_gate_sequencer_test;
	import charge_seq_pkg::*;

	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	localparam int QUAL  = 20;
	localparam int PLO   = `PER_LO_CYC;
	localparam int PHI   = `PER_HI_CYC;
	localparam int LIMIT = 12000;
	logic        clk;
	logic        rst_b;
	logic        pinB;
	logic        leak;
	logic        bootLow;
	logic        shoot;
	logic [31:0] rdata;
	logic [7:0]  duty;
	logic        irq;
	regReq_t     regReq;
	senseIn_t    senseDrv;
	senseIn_t    senseDut;
	gateCmd_t    gates;
	int          fails = 0;
	int          checks = 0;
	int          cyc = 0;

	// the model owns the bootstrap sense line
	always_comb begin
		senseDut = senseDrv;
		senseDut.bootLow = bootLow;
	end

	charge_enable_and_gate_sequencer #(.QUAL_CYCLES(QUAL)) DUT (
		.clk(clk), .rst_b(rst_b), .regReq(regReq), .rdata(rdata),
		.chargeAllowPin_b(pinB), .sense(senseDut), .duty(duty),
		.gates(gates), .irq(irq));

	gate_driver_model drivers (.clk(clk), .rst_b(rst_b), .gates(gates),
		.leak(leak), .bootLow(bootLow), .shoot(shoot));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : end_of_test

	// a hang ends the run as a failure
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == LIMIT) begin
			fails++;
			end_of_test();
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
		input string msg);
		checks++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch at %0t: %s %h not %h", $time, msg, seen, exp);
		end
	endtask : chk

	// sample 1 ns past the edge so the design updates have landed
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick

	task automatic regWr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		regReq.addr <= a;
		regReq.wdata <= d;
		regReq.wr <= 1'b1;
		@(posedge clk);
		regReq.wr <= 1'b0;
	endtask : regWr

	task automatic rdChk(input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] e, input string s);
		@(posedge clk);
		regReq.addr <= a;
		regReq.rd <= 1'b1;
		@(posedge clk);
		regReq.rd <= 1'b0;
		#1;
		chk(rdata & m, e, s);
	endtask : rdChk

	// waits for a gate to reach v; s picks the low side, capped at 500
	task automatic waitGate(input int s, input logic v, output int n);
		n = 0;
		while ((s ? gates.lowSide : gates.highSide) !== v && n < 500) begin
			tick(1);
			n++;
		end
	endtask : waitGate

	// counts cycles in which any gate is on
	task automatic quiet(input int n, inout int on);
		repeat (n) begin
			tick(1);
			if (gates !== 2'b00)
				on++;
		end
	endtask : quiet

	// one full period: high, dead, low, rest up to the next high
	task automatic pattern(input int hw, input int lw, input int per);
		int n;
		waitGate(0, 0, n);
		waitGate(0, 1, n);
		waitGate(0, 0, n);
		chk(n, hw, "high width");
		waitGate(1, 1, n);
		chk(n, `DEAD_CYC, "dead before low");
		waitGate(1, 0, n);
		chk(n, lw, "low width");
		waitGate(0, 1, n);
		chk(n, per - hw - `DEAD_CYC - lw, "rest of period");
	endtask : pattern

	task automatic fault(input int i, input logic v);
		if (i == 4) begin
			regWr(`OFS_CTRL, {31'h0, v});
		end else begin
			@(posedge clk);
			case (i)
				0: senseDrv.dieOverTemp <= v;
				1: senseDrv.overCurrent <= v;
				2: senseDrv.packTempOk <= !v;
				default: pinB <= v;
			endcase
		end
	endtask : fault

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic testReset();
		rdChk(`OFS_CTRL, 32'h21, 32'h01, "ctrl reset");
		rdChk(`OFS_STATUS, 32'h3, 32'h3, "status reset");
		rdChk(`OFS_INT_MASK, 32'hf, 32'h0, "mask reset");
		rdChk(8'h10, 32'hffffffff, 32'h0, "unmapped read");
		chk(irq, 1'b0, "irq at reset");
		$display("reset test done");
	endtask : testReset

	task automatic testQual();
		int on;
		on = 0;
		regWr(`OFS_INT_MASK, 32'h1 << `INT_READY_BIT);
		regWr(`OFS_CTRL, 32'h0);
		@(posedge clk);
		senseDrv.adapterPresent <= 1'b1;
		// a live duty request makes an early enable show on the gates
		duty <= 8'd80;
		quiet(10, on);
		@(posedge clk);
		senseDrv.adapterPresent <= 1'b0;
		@(posedge clk);
		senseDrv.adapterPresent <= 1'b1;
		quiet(14, on);
		rdChk(`OFS_STATUS, 32'h1, 32'h1, "qual restarted");
		chk(on, 0, "gates during qual");
		tick(10);
		rdChk(`OFS_STATUS, 32'h1, 32'h0, "ready after qual");
		chk(irq, 1'b1, "ready irq");
		regWr(`OFS_INT_STS, 32'h1);
		tick(2);
		chk(irq, 1'b0, "ready irq cleared");
		for (int i = 0; i < 2; i++) begin
			@(posedge clk);
			senseDrv.gateRegGood <= (i != 0);
			senseDrv.auxRegGood <= (i == 0);
			tick(3);
			rdChk(`OFS_STATUS, 32'h1, 32'h1, "regulator down");
			@(posedge clk);
			senseDrv.gateRegGood <= 1'b1;
			senseDrv.auxRegGood <= 1'b1;
			tick(QUAL + 5);
		end
		$display("qualification test done");
	endtask : testQual

	task automatic testEnable();
		int n;
		int on;
		for (int i = 0; i < 5; i++) begin
			on = 0;
			regWr(`OFS_INT_STS, 32'h6);
			fault(i, 1'b1);
			tick(2);
			quiet(PLO, on);
			chk(on, 0, "gates with fault");
			rdChk(`OFS_STATUS, 32'h2, 32'h2, "off flag");
			rdChk(`OFS_INT_STS, 32'h6, 32'h4, "off event");
			fault(i, 1'b0);
			waitGate(0, 1, n);
			chk(n < PLO + 3, 1'b1, "restart");
			rdChk(`OFS_STATUS, 32'h2, 32'h0, "on flag");
			rdChk(`OFS_INT_STS, 32'h2, 32'h2, "on event");
		end
		$display("enable test done");
	endtask : testEnable

	task automatic testModes();
		pattern(80 * PLO / 256, `PULSE_CYC, PLO);
		@(posedge clk);
		senseDrv.aboveSync <= 1'b1;
		// synchronous: the dead cycle ahead of the high side eats one cycle
		pattern(80 * PLO / 256 - `DEAD_CYC,
			PLO - 80 * PLO / 256 - `DEAD_CYC, PLO);
		@(posedge clk);
		senseDrv.aboveSync <= 1'b0;
		regWr(`OFS_CTRL, 32'h1 << `CTRL_FSEL_BIT);
		pattern(80 * PHI / 256, `PULSE_CYC, PHI);
		regWr(`OFS_CTRL, 32'h0);
		$display("mode test done");
	endtask : testModes

	task automatic testZero();
		int on;
		on = 0;
		duty <= 8'h00;
		tick(PLO);
		quiet(2 * PLO, on);
		chk(on, 0, "zero duty gates");
		$display("zero duty test done");
	endtask : testZero

	task automatic testBoot();
		int n;
		regWr(`OFS_INT_MASK, 32'h1 << `INT_REFRESH_BIT);
		duty <= 8'hff;
		tick(2 * PLO);
		@(posedge clk);
		leak <= 1'b1;
		@(posedge clk);
		leak <= 1'b0;
		waitGate(0, 0, n);
		chk(n >= 3 * PLO - 2 && n <= 4 * PLO + 3, 1'b1, "refresh at");
		waitGate(1, 1, n);
		chk(n, `DEAD_CYC, "dead before refresh");
		waitGate(1, 0, n);
		chk(n, `PULSE_CYC, "refresh width");
		waitGate(0, 1, n);
		chk(n, `DEAD_CYC, "resume high");
		rdChk(`OFS_INT_STS, 32'h8, 32'h8, "refresh event");
		chk(irq, 1'b1, "refresh irq");
		regWr(`OFS_INT_STS, 32'h8);
		tick(2);
		chk(irq, 1'b0, "refresh irq cleared");
		chk(shoot, 1'b0, "no shoot-through");
		$display("bootstrap test done");
	endtask : testBoot

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		rst_b = 1'b0;
		regReq = '0;
		pinB = 1'b0;
		leak = 1'b0;
		duty = 8'h00;
		senseDrv = 8'b0110_0100;
		repeat (12) @(posedge clk);
		rst_b <= 1'b1;
		tick(3);
		testReset();
		testQual();
		testEnable();
		testModes();
		testZero();
		testBoot();
		end_of_test();
	end
endmodule : charge_enable_and_gate_sequencer_test

// file: testbench/gate_driver_model.sv
// Purpose: external high and low side gate drivers with bootstrap cap
// Assumes: gate commands are registered levels on clk
// Notes:   the cap only sags when the bench pulses leak
`timescale 1ns/100ps

module gate_driver_model (
	input  wire logic                     clk,
	input  wire logic                     rst_b,
	input  wire charge_seq_pkg::gateCmd_t gates,
	input  wire logic                     leak,
	output      logic                     bootLow,
	output      logic                     shoot
);
	import charge_seq_pkg::*;

	// ----------------------------------------------------------------
	// bootstrap and shoot-through
	// ----------------------------------------------------------------
	// the cap drains when leak pulses with the high side on; a low side pulse refills it
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			bootLow <= 1'b0;
		else if (gates.lowSide)
			bootLow <= 1'b0;
		else if (leak && gates.highSide)
			bootLow <= 1'b1;
	end

	// both switches on would short the supply, so it is latched
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			shoot <= 1'b0;
		else if (gates.highSide && gates.lowSide)
			shoot <= 1'b1;
	end
endmodule : gate_driver_model
